// >>> src/dhps_pkg.sv
// constants, register map and carrier types of the head-positioning sequencer
package dhps_pkg;
  // clock and timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int STEP_W_DD_US    = 2;
  localparam int STEP_W_SD_US    = 4;
  localparam int STEP_W_DD_CYC   = (STEP_W_DD_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int STEP_W_SD_CYC   = (STEP_W_SD_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int MS_CYC          = CLK_HZ / 1000;
  localparam int RATE0_MS        = 3;
  localparam int RATE1_MS        = 6;
  localparam int RATE2_MS        = 10;
  localparam int RATE3_MS        = 15;
  localparam int SETTLE_MS       = 15;
  localparam int CNT_W           = 20;
  localparam int VERIFY_REVS     = 5;
  localparam int IDLE_INDEX_MAX  = 15;
  localparam int RESTORE_MAX     = 255;
  // apb register byte offsets
  localparam logic [7:0] CMD_STAT_OFS = 8'h00;
  localparam logic [7:0] TRACK_OFS    = 8'h04;
  localparam logic [7:0] DATA_OFS     = 8'h08;
  localparam logic [7:0] CTRL_OFS     = 8'h0C;
  // command fields
  localparam int RATE_LSB   = 0;
  localparam int VERIFY_BIT = 2;
  localparam int ENGAGE_BIT = 3;
  localparam int UPDATE_BIT = 4;
  localparam int SETTLE_BIT = 2;
  localparam logic [3:0] OP_RESTORE = 4'h0;
  localparam logic [3:0] OP_SEEK    = 4'h1;
  localparam logic [2:0] OP_STEP    = 3'h1;
  localparam logic [2:0] OP_STEP_IN = 3'h2;
  localparam logic [2:0] OP_STEP_OUT = 3'h3;
  localparam logic [3:0] OP_FORCE   = 4'hD;
  localparam logic [7:0] AUTO_RESTORE_CMD = 8'h03;
  // status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_INDEX   = 1;
  localparam int ST_TRACK0  = 2;
  localparam int ST_CRC     = 3;
  localparam int ST_SEEK    = 4;
  localparam int ST_HEAD_OK = 5;
  // control bits
  localparam int CTRL_SLOW  = 0;
  localparam int CTRL_SINGLE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // pin synchroniser order {chip_clear, index, settled, track_zero}
  localparam logic [3:0] PIN_RESET = 4'h9;
  localparam int PIN_TR0 = 0;
  localparam int PIN_SETTLED = 1;
  localparam int PIN_IDX = 2;
  localparam int PIN_CLR = 3;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dhps_apb_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] track;
    logic       crc_ok;
  } dhps_id_field_t;

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_PULSE, S_GAP, S_SETTLE, S_WAIT_SETTLED, S_VERIFY, S_DONE
  } dhps_state_t;
endpackage : dhps_pkg

// >>> src/dhps_sequencer.sv
// head-positioning command sequencer with apb register access
//
// Behaviour
// R1: step pulse 2us double density, 4us single
// R2: keep last direction unless command sets one
// R3: direction high inward, settled before pulse
// R4: rate field picks 3/6/10/15 ms, doubled slow
// R5: verify adds 15 ms settle, 30 slow
// R6: sector commands engage, optional delay, poll settled
// R7: verify: matching track, good crc completes
// R8: matching track, bad crc flags crc, retries
// R9: five revolutions without match give seek error
// R10: engage at start, at verify, on sector commands
// R11: release on h=0 v=0 or 15 idle indexes
// R12: status bit 5 is engage and settled
// R13: h only: no delay; verify: delay then settled
// R14: restore samples track zero, steps until reached
// R15: 255 restore steps without track zero: error
// R16: restore runs when chip clear is released
// R17: seek steps track toward data register
// R18: step issues one pulse, previous direction
// R19: host holds calibration select during chip clear
// R20: host supplies eight-times data-rate oscillator
// R21: bits rate 1:0, verify 2, engage 3, update 4
// R22: step-in moves inward, increments track
// R23: step-out moves outward, decrements track
// R24: busy set on accept, cleared with interrupt
// R25: rate interval separates pulses and final delay
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dhps_sequencer
  import dhps_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // apb slave
  input  wire dhps_pkg::dhps_apb_req_t  apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // drive pins
  input  wire logic                     track_zero_sense,
  input  wire logic                     head_settled_in,
  input  wire logic                     index_in,
  input  wire logic                     chip_clear_in,
  output logic                          step_out,
  output logic                          step_direction_out,
  output logic                          head_engage_out,
  // read channel id fields
  input  wire dhps_pkg::dhps_id_field_t id_field,
  // completion
  output logic                          completion_irq
);
  import dhps_pkg::*;

  // pin synchronisers: change accepted when stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] pin_ff;
  assign pin_raw = {chip_clear_in, index_in, head_settled_in, track_zero_sense};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_ff[g]  <= PIN_RESET[g];
          s2_ff[g]  <= PIN_RESET[g];
          s3_ff[g]  <= PIN_RESET[g];
          pin_ff[g] <= PIN_RESET[g];
        end else begin
          s1_ff[g] <= pin_raw[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            pin_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

  logic pin_d_ff;
  logic clr_d_ff;
  wire  at_track0   = ~pin_ff[PIN_TR0];
  wire  settled     = pin_ff[PIN_SETTLED];
  wire  clr_active  = ~pin_ff[PIN_CLR];
  wire  index_evt   = pin_ff[PIN_IDX] & ~pin_d_ff;
  wire  clr_release = pin_ff[PIN_CLR] & ~clr_d_ff;

  // registers
  dhps_state_t      state_ff;
  dhps_state_t      nxt_state;
  logic [7:0]       cmd_ff;
  logic [7:0]       track_ff;
  logic [7:0]       data_ff;
  logic [1:0]       ctrl_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [7:0]       steps_ff;
  logic [3:0]       idx_cnt_ff;
  logic             busy_ff;
  logic             crc_err_ff;
  logic             seek_err_ff;
  logic             dir_ff;
  logic             step_ff;
  logic             engage_ff;
  logic             irq_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;

  // apb decode
  wire apb_access = apb_req.psel & apb_req.penable;
  wire apb_done   = apb_access & pready_ff;
  wire apb_wr     = apb_done & apb_req.pwrite;
  wire apb_rd     = apb_done & ~apb_req.pwrite;
  wire sel_cmd    = apb_req.paddr == CMD_STAT_OFS;
  wire sel_track  = apb_req.paddr == TRACK_OFS;
  wire sel_data   = apb_req.paddr == DATA_OFS;
  wire sel_ctrl   = apb_req.paddr == CTRL_OFS;
  wire mapped     = sel_cmd | sel_track | sel_data | sel_ctrl;

  // command decode
  wire [7:0] wcmd      = apb_req.pwdata[7:0];
  wire       cmd_force = apb_wr & sel_cmd & (wcmd[7:4] == OP_FORCE);
  wire       cmd_new   = (apb_wr & sel_cmd & ~busy_ff & ~cmd_force & ~clr_active) | clr_release; // R16
  wire [7:0] new_cmd   = clr_release ? AUTO_RESTORE_CMD : wcmd;
  wire       new_pos   = ~new_cmd[7];
  wire       is_pos    = ~cmd_ff[7];
  wire       is_rest   = cmd_ff[7:4] == OP_RESTORE;
  wire       is_seek   = cmd_ff[7:4] == OP_SEEK;
  wire       is_in     = cmd_ff[7:5] == OP_STEP_IN;
  wire       is_out    = cmd_ff[7:5] == OP_STEP_OUT;
  wire       is_single = cmd_ff[7:5] == OP_STEP || is_in || is_out;
  wire       verify    = cmd_ff[VERIFY_BIT]; // R21
  wire       upd_track = cmd_ff[UPDATE_BIT];
  wire       slow      = ctrl_ff[CTRL_SLOW];

  // timing in cycles; slow clock doubles rate and settle intervals
  logic [CNT_W-1:0] rate_cyc;
  always_comb begin
    case (cmd_ff[RATE_LSB +: 2])
      2'h0:    rate_cyc = CNT_W'(RATE0_MS * MS_CYCLES); // R4
      2'h1:    rate_cyc = CNT_W'(RATE1_MS * MS_CYCLES);
      2'h2:    rate_cyc = CNT_W'(RATE2_MS * MS_CYCLES);
      default: rate_cyc = CNT_W'(RATE3_MS * MS_CYCLES);
    endcase
  end
  wire [CNT_W-1:0] gap_cyc    = slow ? (rate_cyc << 1) : rate_cyc; // R4 R25
  wire [CNT_W-1:0] settle_one = CNT_W'(SETTLE_MS * MS_CYCLES);
  wire [CNT_W-1:0] settle_cyc = slow ? (settle_one << 1) : settle_one; // R5
  wire [CNT_W-1:0] width_cyc  = ctrl_ff[CTRL_SINGLE] ? CNT_W'(STEP_W_SD_CYC) : CNT_W'(STEP_W_DD_CYC); // R1
  wire             cnt_end    = cnt_ff == CNT_W'(1);

  // state machine decisions
  wire at_target  = track_ff == data_ff;
  wire going_in   = is_seek ? (data_ff > track_ff) : dir_ff;
  wire need_step  = is_rest ? ~at_track0 : (is_seek ? ~at_target : (steps_ff == 8'h00));
  wire rest_fail  = is_rest & ~at_track0 & (steps_ff == 8'(RESTORE_MAX)); // R15
  wire id_match   = id_field.valid & (id_field.track == track_ff);
  wire rev_out    = index_evt & (idx_cnt_ff == 4'(VERIFY_REVS - 1)); // R9
  wire idle_out   = index_evt & (idx_cnt_ff == 4'(IDLE_INDEX_MAX - 1)); // R11

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (cmd_new) begin
          nxt_state = new_pos ? S_CHECK : (new_cmd[SETTLE_BIT] ? S_SETTLE : S_WAIT_SETTLED); // R6
        end
      end
      S_CHECK: begin
        if (rest_fail) begin
          nxt_state = S_DONE;
        end else if (need_step) begin
          nxt_state = (is_seek & (dir_ff != going_in)) ? S_CHECK : S_PULSE; // R3
        end else begin
          nxt_state = verify ? S_SETTLE : S_DONE; // R13
        end
      end
      S_PULSE: begin
        if (cnt_end) begin
          nxt_state = S_GAP;
        end
      end
      S_GAP: begin
        if (cnt_end) begin
          nxt_state = S_CHECK; // R25
        end
      end
      S_SETTLE: begin
        if (cnt_end) begin
          nxt_state = S_WAIT_SETTLED;
        end
      end
      S_WAIT_SETTLED: begin
        if (settled) begin
          nxt_state = (is_pos & verify) ? S_VERIFY : S_DONE; // R6 R13
        end
      end
      S_VERIFY: begin
        if ((id_match & id_field.crc_ok) | rev_out) begin
          nxt_state = S_DONE; // R7 R9
        end
      end
      S_DONE: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
    if (cmd_force | clr_active) begin
      nxt_state = (state_ff == S_IDLE || state_ff == S_DONE) ? S_IDLE : S_DONE;
    end
  end

  // counter loads on state entry, counts down while in a timed state
  wire enter_timed = (nxt_state != state_ff) &
                     (nxt_state == S_PULSE || nxt_state == S_GAP || nxt_state == S_SETTLE);
  logic [CNT_W-1:0] nxt_cnt;
  always_comb begin
    nxt_cnt = (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
    if (enter_timed) begin
      case (nxt_state)
        S_PULSE: nxt_cnt = width_cyc;
        S_GAP:   nxt_cnt = gap_cyc;
        default: nxt_cnt = settle_cyc;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_IDLE;
      cnt_ff   <= '0;
      pin_d_ff <= 1'b0;
      clr_d_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pin_d_ff <= pin_ff[PIN_IDX];
      clr_d_ff <= pin_ff[PIN_CLR];
    end
  end

  // command, track, direction and step bookkeeping
  wire start_pulse = (state_ff == S_CHECK) & (nxt_state == S_PULSE);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ff   <= 8'h00;
      track_ff <= 8'h00;
      data_ff  <= 8'h00;
      ctrl_ff  <= CTRL_RESET;
      dir_ff   <= 1'b0;
      steps_ff <= 8'h00;
      step_ff  <= 1'b0;
    end else begin
      step_ff <= (nxt_state == S_PULSE); // R1
      if (apb_wr & sel_ctrl) begin
        ctrl_ff <= apb_req.pwdata[1:0];
      end
      if (apb_wr & sel_data & ~busy_ff) begin
        data_ff <= apb_req.pwdata[7:0];
      end
      if (apb_wr & sel_track & ~busy_ff) begin
        track_ff <= apb_req.pwdata[7:0];
      end
      if (cmd_new) begin
        cmd_ff   <= new_cmd;
        steps_ff <= 8'h00;
        if (new_cmd[7:4] == OP_RESTORE || new_cmd[7:5] == OP_STEP_OUT) begin
          dir_ff <= 1'b0; // R3 R23
        end else if (new_cmd[7:5] == OP_STEP_IN) begin
          dir_ff <= 1'b1; // R3 R22
        end
      end
      // direction settles in the check cycle, one edge before the pulse rises
      if (state_ff == S_CHECK && is_seek && !at_target) begin
        dir_ff <= going_in; // R2 R3 R17
      end
      if (start_pulse) begin
        steps_ff <= steps_ff + 8'h01;
        if (is_seek || (is_single && upd_track)) begin
          track_ff <= dir_ff ? track_ff + 8'h01 : track_ff - 8'h01; // R17 R18 R22 R23
        end
      end
      if (state_ff == S_CHECK && is_rest && at_track0) begin
        track_ff <= 8'h00; // R14
      end
    end
  end

  // head engage, index counting and status flags
  wire release_head = cmd_new & new_pos & ~new_cmd[ENGAGE_BIT] & ~new_cmd[VERIFY_BIT];
  wire engage_start = cmd_new & (~new_pos | new_cmd[ENGAGE_BIT]);
  wire engage_late  = (state_ff == S_CHECK) & (nxt_state == S_SETTLE);
  wire done         = state_ff == S_DONE;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      engage_ff   <= 1'b0;
      idx_cnt_ff  <= 4'h0;
      busy_ff     <= 1'b0;
      crc_err_ff  <= 1'b0;
      seek_err_ff <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      if (engage_start | engage_late) begin
        engage_ff <= 1'b1; // R6 R10 R13
      end else if (release_head | (~busy_ff & idle_out)) begin
        engage_ff <= 1'b0; // R11
      end
      if (cmd_new | (nxt_state != state_ff)) begin
        idx_cnt_ff <= 4'h0;
      end else if (index_evt & ((state_ff == S_IDLE) | (state_ff == S_VERIFY))) begin
        idx_cnt_ff <= idx_cnt_ff + 4'h1;
      end
      if (cmd_new) begin
        busy_ff     <= 1'b1; // R24
        crc_err_ff  <= 1'b0;
        seek_err_ff <= 1'b0;
      end else begin
        if (done) begin
          busy_ff <= 1'b0; // R24
        end
        if (state_ff == S_VERIFY && id_match && !id_field.crc_ok) begin
          crc_err_ff <= 1'b1; // R8
        end
        if (rest_fail & (state_ff == S_CHECK) | (state_ff == S_VERIFY) & rev_out & ~(id_match & id_field.crc_ok)) begin
          seek_err_ff <= 1'b1; // R9 R15
        end
      end
      // completion set wins over a status read in the same cycle
      if (done | (cmd_force & ~busy_ff)) begin
        irq_ff <= 1'b1; // R7 R14 R24
      end else if (cmd_new | (apb_rd & sel_cmd)) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // apb answer: one wait state, read data registered
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cmd) begin
      rd_mux[ST_BUSY]    = busy_ff;
      rd_mux[ST_INDEX]   = pin_ff[PIN_IDX];
      rd_mux[ST_TRACK0]  = at_track0;
      rd_mux[ST_CRC]     = crc_err_ff;
      rd_mux[ST_SEEK]    = seek_err_ff;
      rd_mux[ST_HEAD_OK] = engage_ff & settled; // R12
    end else if (sel_track) begin
      rd_mux[7:0] = track_ff;
    end else if (sel_data) begin
      rd_mux[7:0] = data_ff;
    end else if (sel_ctrl) begin
      rd_mux[1:0] = ctrl_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= apb_access & ~pready_ff;
      pslverr_ff <= apb_access & ~pready_ff & ~mapped;
      prdata_ff  <= (apb_access & ~pready_ff & ~apb_req.pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign step_out           = step_ff;
  assign step_direction_out = dir_ff;
  assign head_engage_out    = engage_ff;
  assign completion_irq     = irq_ff;
endmodule : dhps_sequencer
`default_nettype wire

// >>> tb/dhps_sequencer_asserts.sv
// port checker for the head-positioning sequencer
`timescale 1ns/1ns
`default_nettype none
module dhps_sequencer_asserts
  import dhps_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    reset_n,
  // apb
  input wire dhps_pkg::dhps_apb_req_t apb_req,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  // drive and completion
  input wire logic                    chip_clear_in,
  input wire logic                    step_out,
  input wire logic                    step_direction_out,
  input wire logic                    head_engage_out,
  input wire logic                    completion_irq
);
  logic [15:0] hi_cnt_ff;
  logic [15:0] lo_cnt_ff;
  logic [8:0]  steps_ff;
  wire logic   cmd_wr  = apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == CMD_STAT_OFS;
  wire logic   stat_rd = pready && !apb_req.pwrite && apb_req.paddr == CMD_STAT_OFS;
  wire logic   rise    = step_out && hi_cnt_ff == 16'h0000;
  // low count saturates so an old pulse never wraps into a short gap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_ff <= 16'h0000;
      lo_cnt_ff <= 16'hFFFF;
      steps_ff  <= 9'h000;
    end else begin
      hi_cnt_ff <= step_out ? hi_cnt_ff + 16'h0001 : 16'h0000;
      lo_cnt_ff <= step_out ? 16'h0000 : lo_cnt_ff + {15'h0000, lo_cnt_ff != 16'hFFFF};
      steps_ff  <= (cmd_wr || !chip_clear_in) ? 9'h000 : steps_ff + {8'h00, rise};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_width;
    $fell(step_out) |-> hi_cnt_ff == 16'(STEP_W_DD_CYC) || hi_cnt_ff == 16'(STEP_W_SD_CYC);
  endproperty
  a_width: assert property (p_width) else $error("step pulse width wrong");
  property p_dir_hold;
    step_out |-> $stable(step_direction_out);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved at pulse");
  property p_dir_kept;
    $changed(step_direction_out) |-> !completion_irq;
  endproperty
  a_dir_kept: assert property (p_dir_kept) else $error("direction moved while idle");
  property p_gap;
    $rose(step_out) |-> lo_cnt_ff >= 16'(3 * MS_CYCLES);
  endproperty
  a_gap: assert property (p_gap) else $error("step interval too short");
  property p_end_delay;
    $rose(completion_irq) |-> !step_out && lo_cnt_ff >= 16'(3 * MS_CYCLES);
  endproperty
  a_end_delay: assert property (p_end_delay) else $error("completion before step delay");
  property p_step_limit;
    rise |-> steps_ff < 9'h0FF;
  endproperty
  a_step_limit: assert property (p_step_limit) else $error("more than 255 steps");
  property p_busy_irq;
    stat_rd && $past(completion_irq) |-> !prdata[ST_BUSY];
  endproperty
  a_busy_irq: assert property (p_busy_irq) else $error("busy with completion");
  property p_head_ok;
    stat_rd && !head_engage_out && !$past(head_engage_out) |-> !prdata[ST_HEAD_OK];
  endproperty
  a_head_ok: assert property (p_head_ok) else $error("head ok without engage");
  property p_ready;
    pready |-> apb_req.psel && apb_req.penable && $past(apb_req.penable) ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready outside access");
endmodule : dhps_sequencer_asserts
bind dhps_sequencer dhps_sequencer_asserts #(.MS_CYCLES(MS_CYCLES)) dhps_sequencer_asserts_i (
  .clk(clk), .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .chip_clear_in(chip_clear_in), .step_out(step_out), .step_direction_out(step_direction_out),
  .head_engage_out(head_engage_out), .completion_irq(completion_irq));
`default_nettype wire

// >>> tb/dhps_drive_model.sv
// drive model: head position, track zero, settle timer, index and id fields
`timescale 1ns/1ns
`default_nettype none
module dhps_drive_model
  import dhps_pkg::*;
(
  // clock and test controls
  input  wire logic              clk,
  input  wire logic              stuck,
  input  wire logic              crc_bad,
  // step link
  input  wire logic              step_out,
  input  wire logic              step_direction_out,
  input  wire logic              head_engage_out,
  // drive lines
  output logic                   track_zero_sense,
  output logic                   head_settled_in,
  output dhps_pkg::dhps_id_field_t id_field,
  output logic                   index_in,
  output logic [7:0]             cyl
);
  logic step_d = 1'b0;
  logic bad_done = 1'b0;
  int   rev = 0;
  int   hl = 0;
  int   quiet = 0;
  initial begin
    cyl = 8'h05;
    id_field = '0;
  end
  // active low sensor; stuck models a broken sensor
  assign track_zero_sense = !(cyl == 8'h00 && !stuck);
  assign head_settled_in  = hl >= 20;
  assign index_in         = rev < 10;
  always @(posedge clk) begin
    step_d   <= step_out;
    hl       <= head_engage_out ? hl + 1 : 0;
    quiet    <= step_out ? 0 : quiet + 1;
    rev      <= (rev == 399) ? 0 : rev + 1;
    bad_done <= crc_bad && (bad_done || id_field.valid);
    if (step_out && !step_d && step_direction_out) cyl <= cyl + 8'h01;
    else if (step_out && !step_d && cyl != 8'h00) cyl <= cyl - 8'h01;
    // ids only once the head rests; between ids valid is low and the track field flips every cycle
    if (rev % 100 == 50 && head_settled_in && quiet > 200) id_field <= {1'b1, cyl, !(crc_bad && !bad_done)};
    else id_field <= {1'b0, ~id_field.track, ~id_field.crc_ok};
  end
endmodule : dhps_drive_model
`default_nettype wire

// >>> tb/disk_head_positioning_sequencer_test.sv
// self-checking bench for the head-positioning sequencer
`timescale 1ns/1ns
`default_nettype none
module disk_head_positioning_sequencer_test;
  import dhps_pkg::*;
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           chip_clear_in = 1'b1;
  logic           stuck = 1'b0;
  logic           crc_bad = 1'b0;
  dhps_apb_req_t  apb_req = '0;
  dhps_id_field_t id_field;
  logic [31:0]    prdata, q, st, trk;
  logic [7:0]     cyl;
  logic           pready, pslverr, err, step_out, step_direction_out, head_engage_out, completion_irq;
  logic           track_zero_sense, head_settled_in, index_in;
  int             errors = 0;
  int             n_tests = 0;
  int             n_steps = 0;
  int             n0 = 0;
  int             last_w = 0;
  time            t_rise = 0;
  time            t_fall = 0;
  int             last_gap = 0;
  // cmd, target, crc fault, track, cylinder, status
  logic [47:0]    rows [10] = '{48'h10_07_00_07_07_00, 48'h51_00_00_08_08_00, 48'h72_00_00_07_07_00,
    48'h33_00_00_06_06_00, 48'h40_00_00_06_07_00, 48'h14_03_00_03_04_30, 48'h00_00_00_00_00_00,
    48'h1C_02_01_02_02_28, 48'h0B_00_00_00_00_20, 48'h84_00_00_00_00_20};
  dhps_sequencer #(.MS_CYCLES(10)) dhps_sequencer_i (.clk(clk), .reset_n(reset_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .track_zero_sense(track_zero_sense),
    .head_settled_in(head_settled_in), .index_in(index_in), .chip_clear_in(chip_clear_in),
    .step_out(step_out), .step_direction_out(step_direction_out), .head_engage_out(head_engage_out),
    .id_field(id_field), .completion_irq(completion_irq));
  dhps_drive_model dhps_drive_model_i (.clk(clk), .stuck(stuck), .crc_bad(crc_bad), .step_out(step_out),
    .step_direction_out(step_direction_out), .head_engage_out(head_engage_out),
    .track_zero_sense(track_zero_sense), .head_settled_in(head_settled_in), .id_field(id_field),
    .index_in(index_in), .cyl(cyl));
  always #50 clk = ~clk;
  always @(posedge step_out) begin
    last_gap = int'(($time - t_fall) / 100);
    t_rise = $time;
    n_steps++;
  end
  always @(negedge step_out) begin
    last_w = int'(($time - t_rise) / 100);
    t_fall = $time;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // the request is held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, {31'h0, pready});
    if (n >= 20) end_of_test();
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (completion_irq !== 1'b1 && n < lim);
    chk("completion", 1, {31'h0, completion_irq});
    if (n >= lim) end_of_test();
  endtask : wait_irq
  task automatic run(input logic [7:0] c, input logic [7:0] t, input int lim);
    apb(1'b1, DATA_OFS, {24'h0, t}, q);
    apb(1'b1, CMD_STAT_OFS, {24'h0, c}, q);
    wait_irq(lim);
    apb(1'b0, CMD_STAT_OFS, 32'h0, st);
    apb(1'b0, TRACK_OFS, 32'h0, trk);
  endtask : run
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, q);
    chk("ctrl reset", {30'h0, CTRL_RESET}, q);
    chip_clear_in <= 1'b0;
    repeat (10) @(posedge clk);
    chip_clear_in <= 1'b1;
    wait_irq(20000);
    apb(1'b0, TRACK_OFS, 32'h0, trk);
    chk("restore track", 32'h0, trk);
    chk("restore cylinder", 32'h0, {24'h0, cyl});
    $display("chip clear done");
    for (int i = 0; i < 10; i++) begin
      crc_bad <= rows[i][24];
      run(rows[i][47:40], rows[i][39:32], 20000);
      chk("status", {24'h0, rows[i][7:0]}, st & 32'h39);
      chk("track", {24'h0, rows[i][23:16]}, trk);
      chk("cylinder", {24'h0, rows[i][15:8]}, {24'h0, cyl});
      $display("row %0d done", i);
    end
    chk("pulse width", 40, 32'(last_w));
    repeat (7000) @(posedge clk);
    chk("head engaged", 0, {31'h0, head_engage_out});
    $display("idle release done");
    apb(1'b1, CTRL_OFS, 32'h1, q);
    run(8'h50, 8'h00, 20000);
    chk("pulse width", 20, 32'(last_w));
    stuck <= 1'b1;
    n0 = n_steps;
    run(8'h00, 8'h00, 40000);
    chk("step count", 255, 32'(n_steps - n0));
    chk("seek error", 32'h10, st & 32'h10);
    chk("step gap", 1, {31'h0, last_gap >= 2 * RATE0_MS * 10 && last_gap <= 2 * RATE0_MS * 10 + 2});
    $display("restore limit done");
    apb(1'b0, 8'h10, 32'h0, q);
    chk("slave error", 1, {31'h0, err});
    apb(1'b1, CMD_STAT_OFS, 32'hD0, q);
    wait_irq(20);
    $display("unmapped and force done");
    end_of_test();
  end
endmodule : disk_head_positioning_sequencer_test
`default_nettype wire
